// ### hdl/ccsh_handler.sv
// Common command and status handler
//
// Function
// RL1 - Operation-complete query with no argument: immediate in legacy mode, else blocking.
// RL2 - Immediate argument answers at once with current completion state.
// RL3 - Reset command restores defaults, manual mode, clears transient list, keeps stored data.
// RL4 - Controller allows twenty seconds for reset before further commands.
// RL5 - Mask write loads service request enable mask with value 0-255.
// RL6 - Service request enable mask is kept in retained storage.
// RL7 - Mask query returns mask then clears it to zero.
// RL8 - Status byte query returns eight-bit byte then resets it.
// RL9 - Wait command holds off later commands until pending operations complete.
// RL10 - Event status bit 0 set when pending operation completes.
// RL11 - Status byte bit 6 summarises other bits and flags service request.
// RL12 - Set mask bit unmasks status bit; master summary bit never masked.
`default_nettype none
`include "ccsh_regs.svh"
module ccsh_handler #(
  parameter int CLK_HZ = 250000000,
  // Twenty seconds of clocks needs more than 32 bits
  parameter longint RST_CYCLES = longint'(`CCSH_RST_TIME_S) * longint'(CLK_HZ)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Command request
  input wire logic req_valid,
  input wire ccsh_pkg::ccsh_req_s req,
  output logic req_ready,
  // Response
  output logic rsp_valid,
  output ccsh_pkg::ccsh_rsp_s rsp,
  // Instrument status
  input wire logic legacy_compatible_mode,
  input wire logic op_pending,
  input wire logic [6:0] status_sources,
  input wire logic status_clear,
  // Event status register out and clear
  output logic [7:0] standard_event_status_reg,
  input wire logic event_read_clear,
  // Reset effects
  output logic manual_mode_set,
  output logic transient_list_clear,
  output logic reset_busy,
  // Service request
  output logic [7:0] sre_mask,
  output logic service_request
);
  logic [6:0] stb_ff, nxt_stb;
  logic [7:0] evt_ff, nxt_evt;
  logic pend_ff, nxt_pend;
  logic opc_armed_ff, nxt_opc_armed;
  logic [32:0] rst_cnt_ff, nxt_rst_cnt;
  ccsh_pkg::ccsh_state_e state_ff, nxt_state;
  ccsh_pkg::ccsh_rsp_s rsp_ff, nxt_rsp;
  logic rsp_valid_ff, nxt_rsp_valid;
  logic wait_query_ff, nxt_wait_query;
  logic mask_wr;
  logic [7:0] mask_wdata;
  logic [7:0] stb_full;
  logic summary;
  logic take;

  // Retained mask store, untouched by command reset
  ccsh_nv_mask u_mask (
    .clk(clk),
    .por_b(rst_b),
    .wr_en(mask_wr),
    .wr_data(mask_wdata),
    .mask(sre_mask)
  ); // RL6

  // Status byte with summary bit 6
  assign summary = |(stb_ff & {sre_mask[7], sre_mask[5:0]}); // RL11 RL12
  assign stb_full = {stb_ff[6], summary, stb_ff[5:0]}; // RL11
  assign service_request = summary;

  assign req_ready = (state_ff == ccsh_pkg::ST_IDLE);
  assign take = req_valid && req_ready;
  assign rsp_valid = rsp_valid_ff;
  assign rsp = rsp_ff;
  assign standard_event_status_reg = evt_ff;
  assign reset_busy = (state_ff == ccsh_pkg::ST_RESET);
  assign manual_mode_set = take && (req.cmd == ccsh_pkg::CMD_RST); // RL3
  assign transient_list_clear = manual_mode_set; // RL3

  // Next-state logic for command handling and status
  always_comb
  begin
    nxt_state = state_ff;
    nxt_stb = stb_ff | status_sources;
    nxt_evt = evt_ff;
    nxt_pend = op_pending;
    nxt_opc_armed = opc_armed_ff;
    nxt_rst_cnt = rst_cnt_ff;
    nxt_rsp = rsp_ff;
    nxt_rsp_valid = 1'b0;
    nxt_wait_query = wait_query_ff;
    mask_wr = 1'b0;
    mask_wdata = sre_mask;
    if (event_read_clear)
      nxt_evt = `CCSH_EVT_RESET;
    if (status_clear)
      nxt_stb = status_sources;
    // Completion sets event bit; set beats clear
    if (opc_armed_ff && pend_ff && !op_pending)
    begin
      nxt_evt[`CCSH_OPC_BIT] = 1'b1; // RL10
      nxt_opc_armed = 1'b0;
    end
    case (state_ff)
      ccsh_pkg::ST_IDLE:
      begin
        if (take)
        begin
          case (req.cmd)
            ccsh_pkg::CMD_OPC:
            begin
              if (op_pending)
                nxt_opc_armed = 1'b1;
              else
                nxt_evt[`CCSH_OPC_BIT] = 1'b1; // RL10
            end
            ccsh_pkg::CMD_OPC_Q:
            begin
              if (req.arg == ccsh_pkg::ARG_IMMEDIATE ||
                  (req.arg == ccsh_pkg::ARG_NONE && legacy_compatible_mode)) // RL1
              begin
                nxt_rsp = '{data: {7'h00, !op_pending}, is_query: 1'b1}; // RL2
                nxt_rsp_valid = 1'b1;
              end
              else
              begin
                nxt_wait_query = 1'b1; // RL1
                nxt_state = ccsh_pkg::ST_WAIT;
              end
            end
            ccsh_pkg::CMD_RST:
            begin
              nxt_stb = `CCSH_STB_RESET; // RL3
              nxt_evt = `CCSH_EVT_RESET;
              nxt_opc_armed = 1'b0;
              nxt_rst_cnt = 33'(RST_CYCLES - 1);
              nxt_state = ccsh_pkg::ST_RESET;
            end
            ccsh_pkg::CMD_SRE:
            begin
              mask_wr = 1'b1; // RL5
              mask_wdata = req.value;
            end
            ccsh_pkg::CMD_SRE_Q:
            begin
              nxt_rsp = '{data: sre_mask, is_query: 1'b1}; // RL7
              nxt_rsp_valid = 1'b1;
              mask_wr = 1'b1; // RL7
              mask_wdata = 8'h00;
            end
            ccsh_pkg::CMD_STB_Q:
            begin
              nxt_rsp = '{data: stb_full, is_query: 1'b1}; // RL8
              nxt_rsp_valid = 1'b1;
              nxt_stb = status_sources; // RL8
            end
            ccsh_pkg::CMD_WAI:
            begin
              nxt_wait_query = 1'b0;
              nxt_state = ccsh_pkg::ST_WAIT; // RL9
            end
            default:
            begin
              nxt_state = ccsh_pkg::ST_IDLE;
            end
          endcase
        end
      end
      ccsh_pkg::ST_WAIT:
      begin
        // Hold off further commands until work drains
        if (!op_pending)
        begin
          nxt_state = ccsh_pkg::ST_IDLE; // RL9
          if (wait_query_ff)
          begin
            nxt_rsp = '{data: 8'h01, is_query: 1'b1}; // RL1
            nxt_rsp_valid = 1'b1;
          end
          nxt_wait_query = 1'b0;
        end
      end
      ccsh_pkg::ST_RESET:
      begin
        // Reset busy window, controller must wait it out
        if (rst_cnt_ff == 33'h0)
          nxt_state = ccsh_pkg::ST_IDLE; // RL4
        else
          nxt_rst_cnt = rst_cnt_ff - 33'h1;
      end
      default:
      begin
        nxt_state = ccsh_pkg::ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= ccsh_pkg::ST_IDLE;
      stb_ff <= `CCSH_STB_RESET;
      evt_ff <= `CCSH_EVT_RESET;
      pend_ff <= 1'b0;
      opc_armed_ff <= 1'b0;
      rst_cnt_ff <= 33'h0;
      rsp_ff <= '0;
      rsp_valid_ff <= 1'b0;
      wait_query_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      stb_ff <= nxt_stb;
      evt_ff <= nxt_evt;
      pend_ff <= nxt_pend;
      opc_armed_ff <= nxt_opc_armed;
      rst_cnt_ff <= nxt_rst_cnt;
      rsp_ff <= nxt_rsp;
      rsp_valid_ff <= nxt_rsp_valid;
      wait_query_ff <= nxt_wait_query;
    end
  end
endmodule : ccsh_handler
`default_nettype wire

// ### hdl/ccsh_nv_mask.sv
// Retained storage cell for the service request enable mask
`default_nettype none
`include "ccsh_regs.svh"
module ccsh_nv_mask (
  // Clock and power-on reset only
  input wire logic clk,
  input wire logic por_b,
  // Write port
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // Stored mask
  output logic [7:0] mask
);
  logic [7:0] mask_ff;
  logic [7:0] nxt_mask;

  // Load on write, otherwise hold
  always_comb
  begin
    nxt_mask = wr_en ? wr_data : mask_ff;
  end

  // Only the power-on reset touches it, never a command reset
  always_ff @(posedge clk or negedge por_b)
  begin
    if (!por_b)
      mask_ff <= `CCSH_SRE_RESET;
    else
      mask_ff <= nxt_mask;
  end

  assign mask = mask_ff;
endmodule : ccsh_nv_mask
`default_nettype wire

// ### include/ccsh_pkg.sv
// Types for the common command and status handler
`default_nettype none
package ccsh_pkg;
  typedef enum logic [3:0] {
    CMD_OPC = 4'h0,
    CMD_OPC_Q = 4'h1,
    CMD_RST = 4'h2,
    CMD_SRE = 4'h3,
    CMD_SRE_Q = 4'h4,
    CMD_STB_Q = 4'h5,
    CMD_WAI = 4'h6
  } ccsh_cmd_e;
  typedef enum logic [2:0] {
    ARG_NONE = 3'h0,
    ARG_BLOCK = 3'h1,
    ARG_IMMEDIATE = 3'h2
  } ccsh_arg_e;
  typedef struct packed {
    ccsh_cmd_e cmd;
    ccsh_arg_e arg;
    logic [7:0] value;
  } ccsh_req_s;
  typedef struct packed {
    logic [7:0] data;
    logic is_query;
  } ccsh_rsp_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RESET = 3'b100
  } ccsh_state_e;
endpackage : ccsh_pkg
`default_nettype wire

// ### include/ccsh_regs.svh
// Constants for the common command and status handler
`ifndef CCSH_REGS_SVH
`define CCSH_REGS_SVH
`define CCSH_OPC_BIT 0
`define CCSH_SUMMARY_BIT 6
`define CCSH_SRE_RESET 8'h00
`define CCSH_STB_RESET 7'h00
`define CCSH_EVT_RESET 8'h00
`define CCSH_RST_TIME_S 20
`endif

// ### verif/ccsh_ctrl_model.sv
// Remote controller model issuing commands
`default_nettype none
module ccsh_ctrl_model #(
  parameter int RST_CYCLES = 16
) (
  // Clock
  input wire logic clk,
  // Request and answer
  output logic req_valid,
  output ccsh_pkg::ccsh_req_s req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire ccsh_pkg::ccsh_rsp_s rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_valid = 1'b0;
  initial req = '0;
  // One command, held until taken, then its answer
  task automatic send(input ccsh_pkg::ccsh_cmd_e c, input ccsh_pkg::ccsh_arg_e a, input logic [7:0] v,
    output logic [7:0] d, output bit ok);
    int n;
    d = 8'h00;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{c, a, v};
    for (n = 0; n < 400 && !req_ready; n++)
      @(negedge clk);
    ok = req_ready;
    @(negedge clk);
    req_valid = 1'b0;
    req = '{c, a, ~v};
    if (c inside {ccsh_pkg::CMD_OPC_Q, ccsh_pkg::CMD_SRE_Q, ccsh_pkg::CMD_STB_Q})
    begin
      for (n = 0; n < 400 && !rsp_valid; n++)
        @(negedge clk);
      ok = ok && rsp_valid;
      d = rsp.data;
    end
    if (c == ccsh_pkg::CMD_RST)
      repeat (RST_CYCLES + 2) @(negedge clk);
  endtask : send
endmodule : ccsh_ctrl_model
`default_nettype wire

// ### verif/ccsh_handler_monitor.sv
// Checker for the command and status handler
`default_nettype none
module ccsh_handler_monitor (
  // Clock and request
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire ccsh_pkg::ccsh_req_s req,
  input wire logic req_ready,
  // Answer and effects
  input wire logic rsp_valid,
  input wire ccsh_pkg::ccsh_rsp_s rsp,
  input wire logic legacy_compatible_mode,
  input wire logic op_pending,
  input wire logic [7:0] standard_event_status_reg,
  input wire logic manual_mode_set,
  input wire logic transient_list_clear,
  input wire logic reset_busy,
  input wire logic [7:0] sre_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Taken command and argument
  wire logic tk = req_valid && req_ready;
  wire ccsh_pkg::ccsh_cmd_e c = req.cmd;
  wire ccsh_pkg::ccsh_arg_e a = req.arg;
  // A query answer
  sequence ans_s;
    rsp_valid && rsp.is_query;
  endsequence
  sre_load_a: assert property (tk && c == ccsh_pkg::CMD_SRE
    |=> (sre_mask & 8'hbf) == ($past(req.value) & 8'hbf)) else $error("mask load");
  sre_read_a: assert property (tk && c == ccsh_pkg::CMD_SRE_Q
    |=> ans_s ##0 rsp.data == $past(sre_mask) && sre_mask == 8'h00) else $error("mask read");
  opc_now_a: assert property (tk && c == ccsh_pkg::CMD_OPC_Q && a == ccsh_pkg::ARG_IMMEDIATE
    |=> ans_s ##0 rsp.data == {7'h00, !$past(op_pending)}) else $error("quick reply");
  opc_legacy_a: assert property (tk && c == ccsh_pkg::CMD_OPC_Q && a == ccsh_pkg::ARG_NONE
    && legacy_compatible_mode |=> ans_s) else $error("legacy reply");
  opc_block_a: assert property (tk && c == ccsh_pkg::CMD_OPC_Q && a == ccsh_pkg::ARG_BLOCK
    && op_pending |=> !rsp_valid && !req_ready) else $error("early reply");
  wai_hold_a: assert property (tk && c == ccsh_pkg::CMD_WAI && op_pending
    |=> !req_ready) else $error("no hold");
  rst_do_a: assert property (tk && c == ccsh_pkg::CMD_RST
    |-> manual_mode_set && transient_list_clear ##1 reset_busy && !req_ready) else $error("no reset");
  stb_sum_a: assert property (tk && c == ccsh_pkg::CMD_STB_Q
    |=> ans_s ##0 rsp.data[6] == |(rsp.data & $past(sre_mask) & 8'hbf)) else $error("summary");
  opc_set_a: assert property (tk && c == ccsh_pkg::CMD_OPC && !op_pending
    |=> standard_event_status_reg[0]) else $error("complete bit");
endmodule : ccsh_handler_monitor
bind ccsh_handler ccsh_handler_monitor ccsh_handler_monitor_inst (.*);
`default_nettype wire

// ### verif/ccsh_handler_tb.sv
// Testbench for the command and status handler
`default_nettype none
module ccsh_handler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RC = 16;
  logic clk = 1'b0, rst_b = 1'b0, leg = 1'b0, pend = 1'b0, sclr = 1'b0, eclr = 1'b0;
  logic req_valid, req_ready, rsp_valid, busy, srq;
  logic [6:0] src = 7'h00;
  logic [7:0] evs, mask, d, e, m;
  logic [31:0] lf = 32'h9666;
  ccsh_pkg::ccsh_req_s req;
  ccsh_pkg::ccsh_rsp_s rsp;
  int n_errors = 0, cmp_count = 0, i;
  bit ok;
  // Clock
  always #2 clk = ~clk;
  ccsh_handler #(.RST_CYCLES(RC)) ccsh_handler_inst (.clk, .rst_b, .req_valid, .req, .req_ready, .rsp_valid,
    .rsp, .legacy_compatible_mode(leg), .op_pending(pend), .status_sources(src), .status_clear(sclr),
    .standard_event_status_reg(evs), .event_read_clear(eclr), .manual_mode_set(), .transient_list_clear(),
    .reset_busy(busy), .sre_mask(mask), .service_request(srq));
  ccsh_ctrl_model #(.RST_CYCLES(RC)) ccsh_ctrl_model_inst (.clk, .req_valid, .req, .req_ready, .rsp_valid, .rsp);
  // Shift register for random values
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic summarize();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic tx(input ccsh_pkg::ccsh_cmd_e c, input ccsh_pkg::ccsh_arg_e a, input logic [7:0] v);
    ccsh_ctrl_model_inst.send(c, a, v, d, ok);
    if (!ok)
    begin
      n_errors++;
      summarize();
    end
  endtask : tx
  // Main sequence
  initial
  begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    for (i = 0; i < 6; i++)
    begin
      lf = nxt(lf);
      m = lf[7:0];
      tx(ccsh_pkg::CMD_SRE, ccsh_pkg::ARG_NONE, m);
      src = lf[14:8];
      sclr = 1'b1;
      @(negedge clk);
      sclr = 1'b0;
      src = 7'h00;
      e = {lf[14], 1'b0, lf[13:8]};
      e[6] = |(e & m & 8'hbf);
      check("srq", {7'h00, e[6]}, {7'h00, srq});
      tx(ccsh_pkg::CMD_STB_Q, ccsh_pkg::ARG_NONE, 8'h00);
      check("stb", e, d);
      tx(ccsh_pkg::CMD_STB_Q, ccsh_pkg::ARG_NONE, 8'h00);
      check("stb clr", 8'h00, d);
      tx(ccsh_pkg::CMD_SRE_Q, ccsh_pkg::ARG_NONE, 8'h00);
      check("sre", m & 8'hbf, d & 8'hbf);
      tx(ccsh_pkg::CMD_SRE_Q, ccsh_pkg::ARG_NONE, 8'h00);
      check("sre clr", 8'h00, d);
      pend = lf[16];
      tx(ccsh_pkg::CMD_OPC_Q, ccsh_pkg::ARG_IMMEDIATE, 8'h00);
      check("opc now", {7'h00, !lf[16]}, d);
      leg = 1'b1;
      tx(ccsh_pkg::CMD_OPC_Q, ccsh_pkg::ARG_NONE, 8'h00);
      check("opc leg", {7'h00, !lf[16]}, d);
      leg = 1'b0;
      pend = 1'b1;
      fork
        tx(i[0] ? ccsh_pkg::CMD_WAI : ccsh_pkg::CMD_OPC_Q, i[1] ? ccsh_pkg::ARG_BLOCK : ccsh_pkg::ARG_NONE, 8'h00);
        begin
          repeat (i + 3) @(negedge clk);
          check("held", 8'h00, {7'h00, req_ready});
          pend = 1'b0;
        end
      join
      // Let the low pending level reach a clock edge before raising it again
      @(negedge clk);
      check("opc wait", {7'h00, !i[0]}, d);
      pend = 1'b1;
      tx(ccsh_pkg::CMD_OPC, ccsh_pkg::ARG_NONE, 8'h00);
      check("evt early", 8'h00, {7'h00, evs[0]});
      pend = 1'b0;
      repeat (2) @(negedge clk);
      check("evt set", 8'h01, {7'h00, evs[0]});
      eclr = 1'b1;
      @(negedge clk);
      eclr = 1'b0;
    end
    tx(ccsh_pkg::CMD_SRE, ccsh_pkg::ARG_NONE, 8'ha5);
    // Leave an event bit and a status bit set for the reset to clear
    tx(ccsh_pkg::CMD_OPC, ccsh_pkg::ARG_NONE, 8'h00);
    check("evt pre", 8'h01, {7'h00, evs[0]});
    src = 7'h01;
    @(negedge clk);
    src = 7'h00;
    tx(ccsh_pkg::CMD_RST, ccsh_pkg::ARG_NONE, 8'h00);
    check("busy", 8'h00, {7'h00, busy});
    check("evt rst", 8'h00, evs);
    tx(ccsh_pkg::CMD_STB_Q, ccsh_pkg::ARG_NONE, 8'h00);
    check("stb rst", 8'h00, d);
    tx(ccsh_pkg::CMD_SRE_Q, ccsh_pkg::ARG_NONE, 8'h00);
    check("kept", 8'ha5, d);
    summarize();
  end
endmodule : ccsh_handler_tb
`default_nettype wire
